//--- verilog/jtp_pkg.sv
// Shared constants and types for the serial test port block.
// Assumes nothing beyond a SystemVerilog compiler; holds no logic.
package jtp_pkg;

	// -------------------------------------------------------------------
	// Controller states and chain selection
	// -------------------------------------------------------------------
	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
	} jtp_tap_t;

	typedef enum logic [2:0] {
		SEL_BSR, SEL_ABT, SEL_DPA, SEL_APA, SEL_IDC, SEL_BYP
	} jtp_sel_t;

	// -------------------------------------------------------------------
	// Instruction codes and chain sizes
	// -------------------------------------------------------------------
	localparam int JTP_IR_W = 4;
	localparam logic [3:0] JTP_IR_EXT = 4'h0;
	localparam logic [3:0] JTP_IR_INT = 4'h1;
	localparam logic [3:0] JTP_IR_SMP = 4'h2;
	localparam logic [3:0] JTP_IR_ABT = 4'h8;
	localparam logic [3:0] JTP_IR_DPA = 4'ha;
	localparam logic [3:0] JTP_IR_APA = 4'hb;
	localparam logic [3:0] JTP_IR_IDC = 4'he;
	localparam logic [3:0] JTP_IR_BYP = 4'hf;
	localparam logic [3:0] JTP_IR_CAPTURE = 4'h1;
	localparam int JTP_ID_W = 32;
	localparam int JTP_DP_W = 35;
	localparam logic JTP_BYP_CAPTURE = 1'b0;
	localparam int JTP_TMS_RESET_COUNT = 5;

	// -------------------------------------------------------------------
	// Boundary cell layout: three cells per pad, then the reset pin
	// -------------------------------------------------------------------
	localparam int JTP_BS_CELLS = 3;
	localparam int JTP_BS_IN = 0;
	localparam int JTP_BS_OUT = 1;
	localparam int JTP_BS_OE = 2;

	// -------------------------------------------------------------------
	// Port pin defaults
	// -------------------------------------------------------------------
	localparam int JTP_PINS = 5;
	localparam logic [4:0] JTP_AFSEL_RST = 5'h1f;
	localparam logic [4:0] JTP_PUR_RST = 5'h1f;

	// State walk that switches the port to two-wire debug.
	localparam int JTP_SWD_LEN = 17;
	localparam jtp_tap_t JTP_SWD_SEQ [JTP_SWD_LEN] = '{
		TLR, RTI, SEL_DR, SEL_IR, CAP_IR, EX1_IR, UPD_IR,
		RTI, SEL_DR, SEL_IR, CAP_IR, EX1_IR, UPD_IR,
		RTI, SEL_DR, SEL_IR, TLR
	};

endpackage

//--- verilog/jtp_scan_if.sv
// Carries the controller state, serial input and reset to the chains.
// Assumes all users run on the test clock.
`timescale 1ns/1ps
`default_nettype none
interface jtp_scan_if;
	jtp_pkg::jtp_tap_t st;
	logic tdi;
	logic rst;
	modport tap (output st, output tdi, output rst);
	modport chain (input st, input tdi, input rst);
endinterface
`default_nettype wire

//--- verilog/jtp_chain.sv
// One serial chain with its parallel hold register.
// Assumes the controller state and reset arrive on the test clock.
`timescale 1ns/1ps
`default_nettype none
module jtp_chain #(
	parameter int W = 4,
	parameter bit IS_IR = 1'b0,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic tck,
	jtp_scan_if.chain scan,
	input wire logic sel,
	input wire logic [W-1:0] cap_val,
	output logic tdo,
	output logic [W-1:0] hold
);
	logic [W-1:0] sr_q, sr_d, hold_q, hold_d;
	logic cap, sft, upd, ir_rst;

	if (W < 2) begin : g_bad_width
		$error("jtp_chain needs at least two bits");
	end

	always_comb begin
		cap = sel && scan.st == (IS_IR ? jtp_pkg::CAP_IR : jtp_pkg::CAP_DR);
		sft = sel && scan.st == (IS_IR ? jtp_pkg::SH_IR : jtp_pkg::SH_DR);
		upd = sel && scan.st == (IS_IR ? jtp_pkg::UPD_IR : jtp_pkg::UPD_DR);
		ir_rst = IS_IR && scan.st == jtp_pkg::TLR;
		sr_d = sr_q;
		hold_d = hold_q;
		if (scan.rst) begin
			sr_d = '0;
		end else if (cap) begin
			sr_d = cap_val;
		end else if (sft) begin
			sr_d = {scan.tdi, sr_q[W-1:1]};
		end
		if (scan.rst || ir_rst) begin
			hold_d = RST_VAL;
		end else if (upd) begin
			hold_d = sr_q;
		end
	end

	always_ff @(posedge tck) begin
		sr_q <= sr_d;
		hold_q <= hold_d;
	end

	assign tdo = sr_q[0];
	assign hold = hold_q;

	default clocking cb @(posedge tck); endclocking
	default disable iff (scan.rst);

	AST_CHAIN_CAPTURE: assert property (cap |=> sr_q == $past(cap_val))
		else $error("chain did not load its capture value");
	AST_CHAIN_SHIFT: assert property (sft |=> sr_q[W-1] == $past(scan.tdi))
		else $error("chain did not take the serial input");
	AST_CHAIN_UPDATE: assert property (upd && !ir_rst |=> hold_q == $past(sr_q))
		else $error("hold register missed the update");
endmodule
`default_nettype wire

//--- verilog/jtp_swd_det.sv
// Watches the controller walk for the two-wire debug switch preamble.
// Assumes the power-on reset input is already on the test clock.
`timescale 1ns/1ps
`default_nettype none
module jtp_swd_det (
	input wire logic tck,
	input wire logic por,
	jtp_scan_if.chain scan,
	output logic swd_en
);
	logic [4:0] idx_q, idx_d;
	logic swd_q, swd_d;

	always_comb begin
		idx_d = idx_q;
		swd_d = swd_q;
		if (scan.rst) begin
			idx_d = 5'h00;
		end else if (scan.st == jtp_pkg::JTP_SWD_SEQ[idx_q]) begin
			if (idx_q == 5'(jtp_pkg::JTP_SWD_LEN - 1)) begin
				swd_d = 1'b1;
				idx_d = 5'h01;
			end else begin
				idx_d = 5'(idx_q + 5'h01);
			end
		end else begin
			// Any stray state, Shift-IR included, restarts the count.
			idx_d = (scan.st == jtp_pkg::TLR) ? 5'h01 : 5'h00;
		end
		if (por) begin
			swd_d = 1'b0;
		end
	end

	always_ff @(posedge tck) begin
		idx_q <= idx_d;
		swd_q <= swd_d;
	end

	assign swd_en = swd_q;

	AST_SWD_STICKY: assert property (@(posedge tck) disable iff (por)
		swd_q |=> swd_q) else $error("two-wire mode dropped without reset");
	AST_SWD_SHIFT_IR: assert property (@(posedge tck) disable iff (por)
		scan.st == jtp_pkg::SH_IR && !scan.rst |=> idx_q == 5'h00)
		else $error("switch count not restarted by Shift-IR");
endmodule
`default_nettype wire

//--- verilog/jtp_tap.sv
// Serial test port: controller, instruction decode, chains, pad control.
// Assumes ref_clk logic is the core side; tck comes from the probe.
//
// Notes on behaviour
// - Selected chain loads its capture value, then shifts out one bit per clock.
// - While shifting, chain takes serial input; update copies it to the hold.
// - After reset the five port pins select debug function with pull-ups on.
// - Clearing the select bits hands the pins to general I/O.
// - Two instruction load passes without Shift-IR enable two-wire debug.
// - No chain is reachable from the processor bus; serial access only.
// - Instruction register is a four-bit chain with a parallel hold.
// - A new instruction acts only after the update state.
// - Codes 0000, 0001, 0010 select pad drive, core drive, sample.
// - Codes 1000, 1010, 1011 select abort, port access, access-port access.
// - Code 1110 selects identification, 1111 the single-bit bypass.
// - Any unlisted code behaves exactly as bypass.
// - Sample captures input, output and enable of every pad.
// - Pad drive puts preloaded output and enable bits on the pads.
// - Core drive feeds preloaded input bits to the core.
// - Reset pin cell is observe-only and never drives the core.
// - Entering Test-Logic-Reset loads the identification instruction.
// - Five clock edges with mode-select high reach Test-Logic-Reset.
// - Inputs sampled on rising test clock, output changes on falling edge.
// - Identification chain is 32 bits with bit zero one; bypass captures zero.
`timescale 1ns/1ps
`default_nettype none
module jtp_tap #(
	parameter int NPAD = 8,
	// Arbitrary identification value; bit zero is forced to one anyway.
	parameter logic [31:0] ID_VALUE = 32'h00000001
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic tck,
	input wire logic trst_n,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	output logic swd_enable,
	input wire logic sw_afsel_we,
	input wire logic [4:0] sw_afsel_wdata,
	input wire logic sw_pur_we,
	input wire logic [4:0] sw_pur_wdata,
	output logic [4:0] alt_function_select,
	output logic [4:0] pull_up_enable,
	input wire logic [NPAD-1:0] pad_in,
	input wire logic pad_rst_n,
	input wire logic [NPAD-1:0] core_pad_out,
	input wire logic [NPAD-1:0] core_pad_oe,
	output logic [NPAD-1:0] pad_out,
	output logic [NPAD-1:0] pad_oe,
	output logic [NPAD-1:0] core_pad_in,
	input wire logic [34:0] dp_capture,
	input wire logic [34:0] ap_capture,
	output logic [34:0] abort_hold,
	output logic [34:0] dp_hold,
	output logic [34:0] ap_hold
);
	localparam int BSW = jtp_pkg::JTP_BS_CELLS * NPAD + 1;

	if (NPAD < 1) begin : g_bad_npad
		$error("jtp_tap needs at least one pad");
	end

	// The chains have no bus-mapped copy at all.

	// -------------------------------------------------------------------
	// Core-side pin control
	// -------------------------------------------------------------------
	logic [4:0] afsel_q, afsel_d, pur_q, pur_d;
	logic act_q, act_d;

	always_comb begin
		afsel_d = afsel_q;
		pur_d = pur_q;
		if (sys_rst) begin
			afsel_d = jtp_pkg::JTP_AFSEL_RST;
			pur_d = jtp_pkg::JTP_PUR_RST;
		end else begin
			if (sw_afsel_we) begin
				afsel_d = sw_afsel_wdata;
			end
			if (sw_pur_we) begin
				pur_d = sw_pur_wdata;
			end
		end
		// The port listens only while every one of its pins is selected.
		act_d = &afsel_d;
	end

	always_ff @(posedge ref_clk) begin
		afsel_q <= afsel_d;
		pur_q <= pur_d;
		act_q <= act_d;
	end

	assign alt_function_select = afsel_q;
	assign pull_up_enable = pur_q;

	// -------------------------------------------------------------------
	// Test clock domain: synchronisers
	// -------------------------------------------------------------------
	logic trst_s1_q, trst_s2_q, por_s1_q, por_s2_q, act_s1_q, act_s2_q;
	logic [NPAD-1:0] pin_t1_q, pin_t2_q, cout_t1_q, cout_t2_q;
	logic [NPAD-1:0] coe_t1_q, coe_t2_q;
	logic rpin_t1_q, rpin_t2_q;
	logic tck_rst;

	always_ff @(posedge tck) begin
		trst_s1_q <= trst_n;
		trst_s2_q <= trst_s1_q;
		por_s1_q <= sys_rst;
		por_s2_q <= por_s1_q;
		act_s1_q <= act_q;
		act_s2_q <= act_s1_q;
		pin_t1_q <= pad_in;
		pin_t2_q <= pin_t1_q;
		cout_t1_q <= core_pad_out;
		cout_t2_q <= cout_t1_q;
		coe_t1_q <= core_pad_oe;
		coe_t2_q <= coe_t1_q;
		rpin_t1_q <= pad_rst_n;
		rpin_t2_q <= rpin_t1_q;
	end

	assign tck_rst = por_s2_q || !trst_s2_q;

	// -------------------------------------------------------------------
	// Controller state machine
	// -------------------------------------------------------------------
	jtp_pkg::jtp_tap_t tap_q, tap_d;
	jtp_scan_if scan ();

	always_comb begin
		case (tap_q)
			jtp_pkg::TLR: tap_d = tms ? jtp_pkg::TLR : jtp_pkg::RTI;
			jtp_pkg::RTI: tap_d = tms ? jtp_pkg::SEL_DR : jtp_pkg::RTI;
			jtp_pkg::SEL_DR: tap_d = tms ? jtp_pkg::SEL_IR : jtp_pkg::CAP_DR;
			jtp_pkg::CAP_DR: tap_d = tms ? jtp_pkg::EX1_DR : jtp_pkg::SH_DR;
			jtp_pkg::SH_DR: tap_d = tms ? jtp_pkg::EX1_DR : jtp_pkg::SH_DR;
			jtp_pkg::EX1_DR: tap_d = tms ? jtp_pkg::UPD_DR : jtp_pkg::PAU_DR;
			jtp_pkg::PAU_DR: tap_d = tms ? jtp_pkg::EX2_DR : jtp_pkg::PAU_DR;
			jtp_pkg::EX2_DR: tap_d = tms ? jtp_pkg::UPD_DR : jtp_pkg::SH_DR;
			jtp_pkg::UPD_DR: tap_d = tms ? jtp_pkg::SEL_DR : jtp_pkg::RTI;
			jtp_pkg::SEL_IR: tap_d = tms ? jtp_pkg::TLR : jtp_pkg::CAP_IR;
			jtp_pkg::CAP_IR: tap_d = tms ? jtp_pkg::EX1_IR : jtp_pkg::SH_IR;
			jtp_pkg::SH_IR: tap_d = tms ? jtp_pkg::EX1_IR : jtp_pkg::SH_IR;
			jtp_pkg::EX1_IR: tap_d = tms ? jtp_pkg::UPD_IR : jtp_pkg::PAU_IR;
			jtp_pkg::PAU_IR: tap_d = tms ? jtp_pkg::EX2_IR : jtp_pkg::PAU_IR;
			jtp_pkg::EX2_IR: tap_d = tms ? jtp_pkg::UPD_IR : jtp_pkg::SH_IR;
			jtp_pkg::UPD_IR: tap_d = tms ? jtp_pkg::SEL_DR : jtp_pkg::RTI;
			default: tap_d = jtp_pkg::TLR;
		endcase
		// Released pins or a switch to two wires park the controller.
		if (tck_rst || !act_s2_q || swd_enable) begin
			tap_d = jtp_pkg::TLR;
		end
	end

	always_ff @(posedge tck) begin
		tap_q <= tap_d;
	end

	assign scan.st = tap_q;
	assign scan.tdi = tdi;
	assign scan.rst = tck_rst;

	// -------------------------------------------------------------------
	// Instruction register and decode
	// -------------------------------------------------------------------
	logic [3:0] ir_hold;
	logic ir_tdo;
	jtp_pkg::jtp_sel_t dec;
	logic [1:0] mode_d;

	jtp_chain #(
		.W(jtp_pkg::JTP_IR_W),
		.IS_IR(1'b1),
		.RST_VAL(jtp_pkg::JTP_IR_IDC)
	) u_ir (
		.tck(tck),
		.scan(scan),
		.sel(1'b1),
		.cap_val(jtp_pkg::JTP_IR_CAPTURE),
		.tdo(ir_tdo),
		.hold(ir_hold)
	);

	// Decode looks only at the hold register, so shifting is harmless.
	always_comb begin
		case (ir_hold)
			jtp_pkg::JTP_IR_EXT: dec = jtp_pkg::SEL_BSR;
			jtp_pkg::JTP_IR_INT: dec = jtp_pkg::SEL_BSR;
			jtp_pkg::JTP_IR_SMP: dec = jtp_pkg::SEL_BSR;
			jtp_pkg::JTP_IR_ABT: dec = jtp_pkg::SEL_ABT;
			jtp_pkg::JTP_IR_DPA: dec = jtp_pkg::SEL_DPA;
			jtp_pkg::JTP_IR_APA: dec = jtp_pkg::SEL_APA;
			jtp_pkg::JTP_IR_IDC: dec = jtp_pkg::SEL_IDC;
			default: dec = jtp_pkg::SEL_BYP;
		endcase
		mode_d[0] = ir_hold == jtp_pkg::JTP_IR_EXT;
		mode_d[1] = ir_hold == jtp_pkg::JTP_IR_INT;
	end

	// The mode is decoded straight from the hold flops, so it takes effect at the
	// update edge itself even if the probe stops the test clock right after it.
	// The core side syncs it as a quasi-static level, like the preload bits.

	// -------------------------------------------------------------------
	// Data chains
	// -------------------------------------------------------------------
	logic id_tdo, bs_tdo, ab_tdo, dp_tdo, ap_tdo;
	logic byp_q, byp_d;
	logic [BSW-1:0] bs_cap, bs_hold;

	for (genvar k = 0; k < NPAD; k++) begin : g_cells
		assign bs_cap[jtp_pkg::JTP_BS_CELLS*k + jtp_pkg::JTP_BS_IN] = pin_t2_q[k];
		assign bs_cap[jtp_pkg::JTP_BS_CELLS*k + jtp_pkg::JTP_BS_OUT] = cout_t2_q[k];
		assign bs_cap[jtp_pkg::JTP_BS_CELLS*k + jtp_pkg::JTP_BS_OE] = coe_t2_q[k];
	end
	// Reset pin is captured here and nowhere fed back to the core.
	assign bs_cap[BSW-1] = rpin_t2_q;

	jtp_chain #(.W(BSW)) u_bs (
		.tck(tck),
		.scan(scan),
		.sel(dec == jtp_pkg::SEL_BSR),
		.cap_val(bs_cap),
		.tdo(bs_tdo),
		.hold(bs_hold)
	);

	jtp_chain #(.W(jtp_pkg::JTP_ID_W)) u_id (
		.tck(tck),
		.scan(scan),
		.sel(dec == jtp_pkg::SEL_IDC),
		.cap_val({ID_VALUE[31:1], 1'b1}),
		.tdo(id_tdo),
		.hold()
	);

	jtp_chain #(.W(jtp_pkg::JTP_DP_W)) u_abt (
		.tck(tck),
		.scan(scan),
		.sel(dec == jtp_pkg::SEL_ABT),
		.cap_val(35'h000000000),
		.tdo(ab_tdo),
		.hold(abort_hold)
	);

	jtp_chain #(.W(jtp_pkg::JTP_DP_W)) u_dpa (
		.tck(tck),
		.scan(scan),
		.sel(dec == jtp_pkg::SEL_DPA),
		.cap_val(dp_capture),
		.tdo(dp_tdo),
		.hold(dp_hold)
	);

	jtp_chain #(.W(jtp_pkg::JTP_DP_W)) u_apa (
		.tck(tck),
		.scan(scan),
		.sel(dec == jtp_pkg::SEL_APA),
		.cap_val(ap_capture),
		.tdo(ap_tdo),
		.hold(ap_hold)
	);

	always_comb begin
		byp_d = byp_q;
		if (tck_rst) begin
			byp_d = 1'b0;
		end else if (dec == jtp_pkg::SEL_BYP && tap_q == jtp_pkg::CAP_DR) begin
			byp_d = jtp_pkg::JTP_BYP_CAPTURE;
		end else if (dec == jtp_pkg::SEL_BYP && tap_q == jtp_pkg::SH_DR) begin
			byp_d = tdi;
		end
	end

	always_ff @(posedge tck) begin
		byp_q <= byp_d;
	end

	jtp_swd_det u_swd (
		.tck(tck),
		.por(por_s2_q),
		.scan(scan),
		.swd_en(swd_enable)
	);

	// -------------------------------------------------------------------
	// Serial output, changed on the falling edge
	// -------------------------------------------------------------------
	logic tdo_q, tdo_d, tdo_oe_q, tdo_oe_d;

	always_comb begin
		case (dec)
			jtp_pkg::SEL_BSR: tdo_d = bs_tdo;
			jtp_pkg::SEL_ABT: tdo_d = ab_tdo;
			jtp_pkg::SEL_DPA: tdo_d = dp_tdo;
			jtp_pkg::SEL_APA: tdo_d = ap_tdo;
			jtp_pkg::SEL_IDC: tdo_d = id_tdo;
			default: tdo_d = byp_q;
		endcase
		if (tap_q == jtp_pkg::SH_IR) begin
			tdo_d = ir_tdo;
		end
		// Driving only while shifting saves power between scans.
		tdo_oe_d = !tck_rst && (tap_q == jtp_pkg::SH_IR || tap_q == jtp_pkg::SH_DR);
		if (!tdo_oe_d) begin
			tdo_d = 1'b0;
		end
	end

	always_ff @(negedge tck) begin
		tdo_q <= tdo_d;
		tdo_oe_q <= tdo_oe_d;
	end

	assign tdo = tdo_q;
	assign tdo_oe = tdo_oe_q;

	// -------------------------------------------------------------------
	// Core-side pad drive
	// -------------------------------------------------------------------
	// Preload bits cross as quasi-static levels: they only change in
	// Update-DR or on test reset, and the probe waits many core cycles before relying on them.
	logic [BSW-1:0] bsr_s1_q, bsr_s2_q;
	logic [1:0] mode_s1_q, mode_s2_q;
	logic [NPAD-1:0] pin_s1_q, pin_s2_q;
	logic [NPAD-1:0] pad_out_q, pad_out_d, pad_oe_q, pad_oe_d;
	logic [NPAD-1:0] cin_q, cin_d, bs_in_v, bs_out_v, bs_oe_v;

	for (genvar k = 0; k < NPAD; k++) begin : g_drive
		assign bs_in_v[k] = bsr_s2_q[jtp_pkg::JTP_BS_CELLS*k + jtp_pkg::JTP_BS_IN];
		assign bs_out_v[k] = bsr_s2_q[jtp_pkg::JTP_BS_CELLS*k + jtp_pkg::JTP_BS_OUT];
		assign bs_oe_v[k] = bsr_s2_q[jtp_pkg::JTP_BS_CELLS*k + jtp_pkg::JTP_BS_OE];
	end

	always_comb begin
		pad_out_d = mode_s2_q[0] ? bs_out_v : core_pad_out;
		pad_oe_d = mode_s2_q[0] ? bs_oe_v : core_pad_oe;
		cin_d = mode_s2_q[1] ? bs_in_v : pin_s2_q;
		if (sys_rst) begin
			pad_out_d = '0;
			pad_oe_d = '0;
			cin_d = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		bsr_s1_q <= bs_hold;
		bsr_s2_q <= bsr_s1_q;
		mode_s1_q <= mode_d;
		mode_s2_q <= mode_s1_q;
		pin_s1_q <= pad_in;
		pin_s2_q <= pin_s1_q;
		pad_out_q <= pad_out_d;
		pad_oe_q <= pad_oe_d;
		cin_q <= cin_d;
	end

	assign pad_out = pad_out_q;
	assign pad_oe = pad_oe_q;
	assign core_pad_in = cin_q;

	// -------------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------------
	sequence s_tms_five;
		tms [*5];
	endsequence

	AST_TMS_RESET: assert property (@(posedge tck) disable iff (tck_rst)
		s_tms_five |=> tap_q == jtp_pkg::TLR) else $error("five ones missed reset state");
	AST_IR_DEFAULT: assert property (@(posedge tck) disable iff (tck_rst)
		tap_q == jtp_pkg::TLR |=> ir_hold == jtp_pkg::JTP_IR_IDC)
		else $error("reset state did not load identification code");
	AST_UNLISTED_BYPASS: assert property (@(posedge tck) disable iff (tck_rst)
		!(ir_hold inside {4'h0, 4'h1, 4'h2, 4'h8, 4'ha, 4'hb, 4'he}) |-> dec == jtp_pkg::SEL_BYP)
		else $error("unlisted code not treated as bypass");
	AST_PIN_RESET: assert property (@(posedge ref_clk)
		sys_rst |=> afsel_q == jtp_pkg::JTP_AFSEL_RST && pur_q == jtp_pkg::JTP_PUR_RST)
		else $error("pins not back in debug function after reset");
	AST_EXTEST_DRIVE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		mode_s2_q[0] |=> pad_out_q == $past(bs_out_v) && pad_oe_q == $past(bs_oe_v))
		else $error("pads not driven from preload bits");
	AST_INTEST_DRIVE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		mode_s2_q[1] |=> cin_q == $past(bs_in_v)) else $error("core not fed preload bits");
endmodule
`default_nettype wire

//--- tb/jtp_probe.sv
// Probe model: drives the test clock, mode-select and serial input.
// Assumes the device samples on rising and updates its output on falling edges.
`timescale 1ns/1ps
`default_nettype none
module jtp_probe (
	output var logic tck,
	output var logic tms,
	output var logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe
);
	logic oe_seen;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		oe_seen = 1'b0;
	end
	// The clock stands low between frames, so inputs only move while it is low.
	task automatic clk(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#40;
		o = tdo;
		if (tdo_oe === 1'b1)
			oe_seen = 1'b1;
		tck = 1'b1;
		#40;
		tck = 1'b0;
	endtask
	task automatic walk(input logic [15:0] m, input int n);
		logic o;
		for (int i = 0; i < n; i++)
			clk(m[i], 1'($urandom), o);
	endtask
	// Five ones reach Test-Logic-Reset from anywhere, then one zero idles.
	task automatic goto_rti;
		walk(16'h001f, 6);
	endtask
	// Starts and ends in Run-Test-Idle; bit 0 goes first in both directions.
	task automatic scan(input logic ir, input int n, input logic [34:0] d, output logic [34:0] q);
		logic o;
		q = '0;
		oe_seen = 1'b0;
		walk(ir ? 16'h0003 : 16'h0001, ir ? 4 : 3);
		for (int i = 0; i < n; i++) begin
			clk(i == n - 1, d[i], o);
			q[i] = o;
		end
		walk(16'h0001, 2);
	endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the serial test port with a probe model.
// Assumes the probe model and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int NP = 2;
	localparam int BL = 3 * NP + 1;
	// Arbitrary identification value with bit zero set.
	localparam logic [31:0] IDV = 32'h0000a5c3;
	logic ref_clk, sys_rst, trst_n, tck, tms, tdi, tdo, tdo_oe, swd_enable;
	logic sw_afsel_we, sw_pur_we, pad_rst_n;
	logic [4:0] sw_afsel_wdata, sw_pur_wdata, alt_function_select, pull_up_enable;
	logic [NP-1:0] pad_in, core_pad_out, core_pad_oe, pad_out, pad_oe, core_pad_in;
	logic [34:0] dp_capture, ap_capture, abort_hold, dp_hold, ap_hold, d, q, p;
	int fail_count = 0;
	int n_compared = 0;
	jtp_tap #(.NPAD(NP), .ID_VALUE(IDV)) u_jtp_tap (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
		.swd_enable(swd_enable), .sw_afsel_we(sw_afsel_we), .sw_afsel_wdata(sw_afsel_wdata),
		.sw_pur_we(sw_pur_we), .sw_pur_wdata(sw_pur_wdata),
		.alt_function_select(alt_function_select), .pull_up_enable(pull_up_enable),
		.pad_in(pad_in), .pad_rst_n(pad_rst_n), .core_pad_out(core_pad_out),
		.core_pad_oe(core_pad_oe), .pad_out(pad_out), .pad_oe(pad_oe),
		.core_pad_in(core_pad_in), .dp_capture(dp_capture), .ap_capture(ap_capture),
		.abort_hold(abort_hold), .dp_hold(dp_hold), .ap_hold(ap_hold));
	jtp_probe u_jtp_probe (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
	always #12.5 ref_clk = ~ref_clk;
	// -------------------------------------------------------------------
	// Reference model and helpers
	// -------------------------------------------------------------------
	function automatic int cap_len(input logic [3:0] c);
		case (c)
			4'h0, 4'h1, 4'h2: return BL;
			4'h8, 4'ha, 4'hb: return 35;
			4'he: return 32;
			default: return 2;
		endcase
	endfunction
	function automatic logic [34:0] exp_out(input logic [3:0] c, input logic [34:0] v);
		logic [34:0] e;
		e = '0;
		case (c)
			4'h2: begin
				for (int k = 0; k < NP; k++) begin
					e[3*k] = pad_in[k];
					e[3*k+1] = core_pad_out[k];
					e[3*k+2] = core_pad_oe[k];
				end
				e[BL-1] = pad_rst_n;
			end
			4'h8: e = '0;
			4'ha: e = dp_capture;
			4'hb: e = ap_capture;
			4'he: e = 35'(IDV);
			default: e = {33'h0, v[0], 1'b0};
		endcase
		return e;
	endfunction
	task automatic check(input string name, input logic [34:0] seen, input logic [34:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic load_ir(input logic [3:0] c);
		u_jtp_probe.scan(1'b1, 4, {31'h0, c}, q);
		check("ir_capture", q, 35'h1);
	endtask
	task automatic pin_wr(input logic a, input logic [4:0] v);
		@(negedge ref_clk);
		sw_afsel_we = a;
		sw_pur_we = !a;
		sw_afsel_wdata = v;
		sw_pur_wdata = v;
		@(negedge ref_clk);
		sw_afsel_we = 1'b0;
		sw_pur_we = 1'b0;
		@(negedge ref_clk);
	endtask
	task automatic reset_run;
		sys_rst = 1'b1;
		fork
			repeat (16) @(posedge ref_clk);
			u_jtp_probe.walk(16'h001f, 4);
		join
		@(negedge ref_clk);
		sys_rst = 1'b0;
	endtask
	task automatic report_and_stop;
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#2000000;
		fail_count++;
		report_and_stop();
	end
	// -------------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		trst_n = 1'b0;
		sw_afsel_we = 1'b0;
		sw_pur_we = 1'b0;
		sw_afsel_wdata = 5'h00;
		sw_pur_wdata = 5'h00;
		void'($urandom(24));
		pad_in = NP'($urandom);
		core_pad_out = NP'($urandom);
		core_pad_oe = NP'($urandom);
		pad_rst_n = 1'($urandom);
		dp_capture = 35'({$urandom, $urandom});
		ap_capture = 35'({$urandom, $urandom});
		reset_run();
		trst_n = 1'b1;
		check("afsel", 35'(alt_function_select), 35'h1f);
		check("pur", 35'(pull_up_enable), 35'h1f);
		u_jtp_probe.goto_rti();
		u_jtp_probe.scan(1'b0, 32, 35'h0, q);
		check("id_default", q, 35'(IDV));
		for (int c = 0; c < 16; c++) begin
			load_ir(4'(c));
			d = 35'({$urandom, $urandom});
			u_jtp_probe.scan(1'b0, cap_len(4'(c)), d, q);
			if (c > 1)
				check("dr_capture", q, exp_out(4'(c), d));
			case (c)
				8: check("abort_hold", abort_hold, d);
				10: check("dp_hold", dp_hold, d);
				11: check("ap_hold", ap_hold, d);
				default: ;
			endcase
		end
		load_ir(4'h2);
		p = 35'($urandom);
		u_jtp_probe.scan(1'b0, BL, p, q);
		check("sample", q, exp_out(4'h2, p));
		load_ir(4'h0);
		repeat (6) @(negedge ref_clk);
		check("pad_out", 35'(pad_out), 35'({p[4], p[1]}));
		check("pad_oe", 35'(pad_oe), 35'({p[5], p[2]}));
		load_ir(4'h1);
		repeat (6) @(negedge ref_clk);
		check("core_in", 35'(core_pad_in), 35'({p[3], p[0]}));
		check("pad_out_core", 35'(pad_out), 35'(core_pad_out));
		load_ir(4'hf);
		u_jtp_probe.goto_rti();
		u_jtp_probe.scan(1'b0, 32, 35'h0, q);
		check("id_after_ones", q, 35'(IDV));
		pin_wr(1'b1, 5'h00);
		check("afsel_clear", 35'(alt_function_select), 35'h0);
		u_jtp_probe.goto_rti();
		u_jtp_probe.scan(1'b1, 4, 35'hf, q);
		check("oe_released", 35'(u_jtp_probe.oe_seen), 35'h0);
		pin_wr(1'b1, 5'h1f);
		d = 35'($urandom % 32);
		pin_wr(1'b0, d[4:0]);
		check("pur_write", 35'(pull_up_enable), d);
		pin_wr(1'b0, 5'h1f);
		u_jtp_probe.goto_rti();
		load_ir(4'he);
		check("oe_restored", 35'(u_jtp_probe.oe_seen), 35'h1);
		u_jtp_probe.walk(16'h001f, 5);
		u_jtp_probe.walk(16'h0066, 8);
		u_jtp_probe.walk(16'h01db, 9);
		check("swd_broken", 35'(swd_enable), 35'h0);
		u_jtp_probe.walk(16'h001f, 5);
		u_jtp_probe.walk(16'hedb6, 16);
		u_jtp_probe.walk(16'h001f, 2);
		check("swd_on", 35'(swd_enable), 35'h1);
		reset_run();
		check("swd_por", 35'(swd_enable), 35'h0);
		check("afsel_rst", 35'(alt_function_select), 35'h1f);
		report_and_stop();
	end
endmodule
`default_nettype wire
